// File: rtl/host_stream_axis_ports.sv
// application-facing stream ports with loopback, file-open outputs and seek stub
// Function
// - each stream port carries only data, valid and ready.
// - there is no end-of-packet marker; each stream is an endless word sequence.
// - port names start with a direction prefix followed by the host file name.
// - each stream has a file-open output, high while its host file is open.
// - all stream ports run on the application clock and are sampled on it.
// - the application clock is derived from the core's internal interface clock.
// - by default the wide and byte host-to-logic streams loop back to their outbound pairs.
// - internal buffering moves words between the core rate and the application rate.
// - addressable streams get no application-side port.
// - an addressable stream reads end-of-file one cycle after the request and its writes never complete.
module host_stream_axis_ports #(
    parameter int APP_DIV = stream_port_pkg::APP_CLOCK_DIV
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic loopback_en_i,
    input wire logic [3:0] file_open_i,
    output logic [3:0] file_open_o,
    output logic application_clock_ce_o,
    input wire stream_port_pkg::wide_word_type core_in_wide_i,
    output logic core_in_wide_ready_o,
    input wire stream_port_pkg::byte_word_type core_in_byte_i,
    output logic core_in_byte_ready_o,
    output stream_port_pkg::wide_word_type core_out_wide_o,
    input wire logic core_out_wide_ready_i,
    output stream_port_pkg::byte_word_type core_out_byte_o,
    input wire logic core_out_byte_ready_i,
    output logic [31:0] inbound_write_32_tdata_o,
    output logic inbound_write_32_tvalid_o,
    input wire logic inbound_write_32_tready_i,
    output logic [7:0] inbound_write_8_tdata_o,
    output logic inbound_write_8_tvalid_o,
    input wire logic inbound_write_8_tready_i,
    input wire logic [31:0] outbound_read_32_tdata_i,
    input wire logic outbound_read_32_tvalid_i,
    output logic outbound_read_32_tready_o,
    input wire logic [7:0] outbound_read_8_tdata_i,
    input wire logic outbound_read_8_tvalid_i,
    output logic outbound_read_8_tready_o,
    input wire logic seek_read_req_i,
    output logic seek_eof_o,
    input wire logic seek_write_valid_i,
    output logic seek_write_ready_o
);
    localparam int DIV_W = $clog2(APP_DIV + 1);

    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic ce_reg;
    logic ce_next;
    logic [3:0] open_reg;
    logic eof_reg;
    logic eof_next;

    logic [31:0] wide_loop_data;
    logic wide_loop_valid;
    logic outbound_wide_loop_sink;
    logic [7:0] byte_loop_data;
    logic byte_loop_valid;
    logic outbound_byte_loop_sink;
    logic [31:0] wide_src_data;
    logic wide_src_valid;
    logic wide_src_ready;
    logic [7:0] byte_src_data;
    logic byte_src_valid;
    logic byte_src_ready;

    // application rate as an enable pulse taken from the core clock
    always_comb
    begin
        div_next = div_reg + DIV_W'(1);
        ce_next = 1'b0;
        if (div_reg == DIV_W'(APP_DIV - 1))
        begin
            div_next = '0;
            ce_next = 1'b1;
        end
    end

    // a seekable read has nothing to return, so it answers end-of-file next cycle
    always_comb
    begin
        eof_next = seek_read_req_i;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_reg <= '0;
            ce_reg <= 1'b0;
            open_reg <= 4'h0;
            eof_reg <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            ce_reg <= ce_next;
            open_reg <= file_open_i;
            eof_reg <= eof_next;
        end
    end

    assign application_clock_ce_o = ce_reg;
    assign file_open_o = open_reg;
    assign seek_eof_o = eof_reg;
    // nothing consumes seekable writes, and no application port exists for them
    assign seek_write_ready_o = 1'b0;

    // inbound stages: core rate in, application rate out
    stream_stage #(.WIDTH(stream_port_pkg::WIDE_W)) in_wide_stage (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .flush_i(~open_reg[stream_port_pkg::IDX_IN_WIDE]),
        .in_ce_i(1'b1),
        .in_valid_i(core_in_wide_i.valid),
        .in_data_i(core_in_wide_i.data),
        .in_ready_o(core_in_wide_ready_o),
        .out_ce_i(ce_reg),
        .out_valid_o(wide_loop_valid),
        .out_data_o(wide_loop_data),
        .out_ready_i(outbound_wide_loop_sink)
    );

    stream_stage #(.WIDTH(stream_port_pkg::BYTE_W)) in_byte_stage (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .flush_i(~open_reg[stream_port_pkg::IDX_IN_BYTE]),
        .in_ce_i(1'b1),
        .in_valid_i(core_in_byte_i.valid),
        .in_data_i(core_in_byte_i.data),
        .in_ready_o(core_in_byte_ready_o),
        .out_ce_i(ce_reg),
        .out_valid_o(byte_loop_valid),
        .out_data_o(byte_loop_data),
        .out_ready_i(outbound_byte_loop_sink)
    );

    // loopback hides the application ports of both pairs while active
    always_comb
    begin
        inbound_write_32_tdata_o = wide_loop_data;
        inbound_write_8_tdata_o = byte_loop_data;
        if (loopback_en_i)
        begin
            inbound_write_32_tvalid_o = 1'b0;
            inbound_write_8_tvalid_o = 1'b0;
            outbound_read_32_tready_o = 1'b0;
            outbound_read_8_tready_o = 1'b0;
            wide_src_data = wide_loop_data;
            wide_src_valid = wide_loop_valid;
            outbound_wide_loop_sink = wide_src_ready;
            byte_src_data = byte_loop_data;
            byte_src_valid = byte_loop_valid;
            outbound_byte_loop_sink = byte_src_ready;
        end
        else
        begin
            inbound_write_32_tvalid_o = wide_loop_valid;
            inbound_write_8_tvalid_o = byte_loop_valid;
            outbound_wide_loop_sink = inbound_write_32_tready_i;
            outbound_byte_loop_sink = inbound_write_8_tready_i;
            wide_src_data = outbound_read_32_tdata_i;
            wide_src_valid = outbound_read_32_tvalid_i;
            outbound_read_32_tready_o = wide_src_ready;
            byte_src_data = outbound_read_8_tdata_i;
            byte_src_valid = outbound_read_8_tvalid_i;
            outbound_read_8_tready_o = byte_src_ready;
        end
    end

    // outbound stages: application rate in, core rate out
    stream_stage #(.WIDTH(stream_port_pkg::WIDE_W)) out_wide_stage (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .flush_i(~open_reg[stream_port_pkg::IDX_OUT_WIDE]),
        .in_ce_i(ce_reg),
        .in_valid_i(wide_src_valid),
        .in_data_i(wide_src_data),
        .in_ready_o(wide_src_ready),
        .out_ce_i(1'b1),
        .out_valid_o(core_out_wide_o.valid),
        .out_data_o(core_out_wide_o.data),
        .out_ready_i(core_out_wide_ready_i)
    );

    stream_stage #(.WIDTH(stream_port_pkg::BYTE_W)) out_byte_stage (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .flush_i(~open_reg[stream_port_pkg::IDX_OUT_BYTE]),
        .in_ce_i(ce_reg),
        .in_valid_i(byte_src_valid),
        .in_data_i(byte_src_data),
        .in_ready_o(byte_src_ready),
        .out_ce_i(1'b1),
        .out_valid_o(core_out_byte_o.valid),
        .out_data_o(core_out_byte_o.data),
        .out_ready_i(core_out_byte_ready_i)
    );

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    chk_seek_eof_now: assert property (seek_read_req_i |=> seek_eof_o)
        else $error("seek read did not return end-of-file next cycle");
    chk_seek_write_stall: assert property (seek_write_valid_i |-> ##[0:8] !seek_write_ready_o)
        else $error("seekable write was accepted");
    chk_open_follows: assert property ($rose(file_open_i[0]) |=> file_open_o[0])
        else $error("file-open output did not follow host open");
    chk_close_follows: assert property ($fell(file_open_i[1]) |=> !file_open_o[1])
        else $error("file-open output did not follow host close");
    chk_loop_hides_ports: assert property (loopback_en_i |-> !inbound_write_32_tvalid_o
        && !outbound_read_32_tready_o && !inbound_write_8_tvalid_o
        && !outbound_read_8_tready_o)
        else $error("application port active during loopback");
    chk_ce_single_pulse: assert property (application_clock_ce_o |=> !application_clock_ce_o)
        else $error("application enable longer than one cycle");
    chk_wide_hold: assert property (inbound_write_32_tvalid_o && !inbound_write_32_tready_i
        && file_open_i[0] && file_open_o[0] && !loopback_en_i |=>
        inbound_write_32_tvalid_o && $stable(inbound_write_32_tdata_o))
        else $error("wide inbound word dropped before transfer");
    chk_byte_hold: assert property (inbound_write_8_tvalid_o && !inbound_write_8_tready_i
        && file_open_i[1] && file_open_o[1] && !loopback_en_i |=>
        inbound_write_8_tvalid_o && $stable(inbound_write_8_tdata_o))
        else $error("byte inbound word dropped before transfer");
    chk_closed_idle: assert property (!file_open_o[0] ##1 !file_open_o[0]
        |-> !wide_loop_valid)
        else $error("closed stream still holds a word");

    cov_loop_word: cover property (loopback_en_i && wide_loop_valid && wide_src_ready && ce_reg);
    cov_app_word: cover property (inbound_write_32_tvalid_o && inbound_write_32_tready_i && ce_reg);
    cov_out_word: cover property (core_out_byte_o.valid && core_out_byte_ready_i);
    cov_seek_eof: cover property (seek_eof_o);
endmodule

// File: rtl/stream_port_pkg.sv
// shared constants and carrier types for the host stream port set
package stream_port_pkg;
    localparam int WIDE_W = 32;
    localparam int BYTE_W = 8;
    localparam int APP_CLOCK_DIV = 2;
    localparam int STREAM_COUNT = 4;
    localparam int IDX_IN_WIDE = 0;
    localparam int IDX_IN_BYTE = 1;
    localparam int IDX_OUT_WIDE = 2;
    localparam int IDX_OUT_BYTE = 3;
    localparam logic LOOPBACK_DEFAULT = 1'b1;

    typedef struct packed {
        logic valid;
        logic [WIDE_W-1:0] data;
    } wide_word_type;

    typedef struct packed {
        logic valid;
        logic [BYTE_W-1:0] data;
    } byte_word_type;
endpackage

// File: rtl/stream_stage.sv
// one-word holding stage that moves stream words between core and application rate
module stream_stage #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_ce_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    input wire logic out_ce_i,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic full_reg;
    logic full_next;
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;
    logic in_fire;
    logic out_fire;

    // half throughput is traded for a flop-only path with no bypass mux
    assign in_ready_o = ~full_reg & ~flush_i;
    assign out_valid_o = full_reg;
    assign out_data_o = data_reg;
    assign in_fire = in_valid_i & in_ready_o & in_ce_i;
    assign out_fire = full_reg & out_ready_i & out_ce_i;

    always_comb
    begin
        full_next = full_reg;
        data_next = data_reg;
        if (flush_i)
        begin
            full_next = 1'b0;
        end
        else if (out_fire)
        begin
            full_next = 1'b0;
        end
        else if (in_fire)
        begin
            full_next = 1'b1;
            data_next = in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            full_reg <= 1'b0;
            data_reg <= '0;
        end
        else
        begin
            full_reg <= full_next;
            data_reg <= data_next;
        end
    end
endmodule

// File: sim/app_side_model.sv
// application-side partner model for the wide streams
module app_side_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic stall_i,
    input wire logic send_i,
    input wire logic [31:0] send_data_i,
    input wire logic [31:0] in_tdata_i,
    input wire logic in_tvalid_i,
    output logic in_tready_o,
    output logic [31:0] out_tdata_o,
    output logic out_tvalid_o,
    input wire logic out_tready_i,
    output logic [31:0] got_data_o,
    output logic [7:0] got_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pend;
    logic [31:0] word;
    assign in_tready_o = !stall_i;
    // idle data shows the inverse so a stale word cannot pass for a new one
    assign out_tvalid_o = pend;
    assign out_tdata_o = pend ? word : ~word;
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pend <= 1'b0;
            word <= 32'h0;
            got_data_o <= 32'h0;
            got_count_o <= 8'h0;
        end
        else
        begin
            // handshakes count only on application clock enable cycles
            if (ce_i && in_tvalid_i && in_tready_o)
            begin
                got_data_o <= in_tdata_i;
                got_count_o <= got_count_o + 8'h1;
            end
            if (ce_i && pend && out_tready_i)
                pend <= 1'b0;
            if (send_i)
            begin
                pend <= 1'b1;
                word <= send_data_i;
            end
        end
    end
endmodule

// File: sim/tb_host_stream_axis_ports.sv
// self-checking bench for the host stream port set
module tb_host_stream_axis_ports;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic loopback_en_i = 1'b0;
    logic [3:0] file_open_i = 4'h0;
    logic [3:0] file_open_o;
    logic application_clock_ce_o;
    stream_port_pkg::wide_word_type core_in_wide_i = '0;
    stream_port_pkg::byte_word_type core_in_byte_i = '0;
    stream_port_pkg::wide_word_type core_out_wide_o;
    stream_port_pkg::byte_word_type core_out_byte_o;
    logic core_in_wide_ready_o, core_in_byte_ready_o, outbound_read_32_tready_o;
    logic core_out_wide_ready_i = 1'b0, core_out_byte_ready_i = 1'b0;
    logic [31:0] inbound_write_32_tdata_o, outbound_read_32_tdata_i, got_data;
    logic [7:0] inbound_write_8_tdata_o, got_count;
    logic inbound_write_32_tvalid_o, inbound_write_32_tready_i, outbound_read_32_tvalid_i;
    logic inbound_write_8_tvalid_o, inbound_write_8_tready_i = 1'b0;
    logic [7:0] outbound_read_8_tdata_i = 8'h00;
    logic outbound_read_8_tvalid_i = 1'b0;
    logic outbound_read_8_tready_o;
    logic seek_read_req_i = 1'b0, seek_write_valid_i = 1'b1, seek_eof_o, seek_write_ready_o;
    logic stall = 1'b1, send = 1'b0;
    int fails = 0;
    int tests_run = 0;

    host_stream_axis_ports i_host_stream_axis_ports (.core_clk_i, .rst_i, .loopback_en_i,
        .file_open_i, .file_open_o, .application_clock_ce_o, .core_in_wide_i,
        .core_in_wide_ready_o, .core_in_byte_i, .core_in_byte_ready_o, .core_out_wide_o,
        .core_out_wide_ready_i, .core_out_byte_o, .core_out_byte_ready_i,
        .inbound_write_32_tdata_o, .inbound_write_32_tvalid_o, .inbound_write_32_tready_i,
        .inbound_write_8_tdata_o, .inbound_write_8_tvalid_o, .inbound_write_8_tready_i,
        .outbound_read_32_tdata_i, .outbound_read_32_tvalid_i, .outbound_read_32_tready_o,
        .outbound_read_8_tdata_i, .outbound_read_8_tvalid_i,
        .outbound_read_8_tready_o, .seek_read_req_i, .seek_eof_o, .seek_write_valid_i,
        .seek_write_ready_o);

    app_side_model i_app_side_model (.core_clk_i,
        .rst_i(rst_i || !file_open_o[stream_port_pkg::IDX_IN_WIDE]),
        .ce_i(application_clock_ce_o),
        .stall_i(stall), .send_i(send), .send_data_i(32'h1234_5678),
        .in_tdata_i(inbound_write_32_tdata_o), .in_tvalid_i(inbound_write_32_tvalid_o),
        .in_tready_o(inbound_write_32_tready_i), .out_tdata_o(outbound_read_32_tdata_i),
        .out_tvalid_o(outbound_read_32_tvalid_i), .out_tready_i(outbound_read_32_tready_o),
        .got_data_o(got_data), .got_count_o(got_count));

    initial
    begin
        forever #50 core_clk_i = !core_clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // request held until ready is seen high at the taking edge
    task automatic push(input logic wide, input logic [31:0] d);
        int n;
        if (wide)
            core_in_wide_i = {1'b1, d};
        else
            core_in_byte_i = {1'b1, d[7:0]};
        #1;
        for (n = 0; n < 40 && (wide ? core_in_wide_ready_o : core_in_byte_ready_o) !== 1'b1; n++)
            @(negedge core_clk_i);
        check({31'h0, wide ? core_in_wide_ready_o : core_in_byte_ready_o}, 32'h1);
        @(negedge core_clk_i);
        if (wide)
            core_in_wide_i = '0;
        else
            core_in_byte_i = '0;
    endtask

    task automatic wait_hi(input int which);
        int n;
        for (n = 0; n < 40; n++)
        begin
            if ((which == 0 ? inbound_write_32_tvalid_o : which == 1 ? inbound_write_8_tvalid_o
                : which == 2 ? core_out_wide_o.valid : core_out_byte_o.valid) === 1'b1)
                break;
            @(negedge core_clk_i);
        end
        check({31'h0, n < 40}, 32'h1);
    endtask

    task automatic t_open();
        int k;
        check({28'h0, file_open_o}, 32'h0);
        file_open_i = 4'h5;
        @(negedge core_clk_i);
        check({28'h0, file_open_o}, 32'h5);
        file_open_i = 4'hF;
        @(negedge core_clk_i);
        check({28'h0, file_open_o}, 32'hF);
        k = 0;
        repeat (10)
        begin
            @(negedge core_clk_i);
            k += application_clock_ce_o;
        end
        check(k, 32'hA / stream_port_pkg::APP_CLOCK_DIV);
    endtask

    task automatic t_inbound();
        push(1'b1, 32'hA5C3_0F96);
        wait_hi(0);
        repeat (4) @(negedge core_clk_i);
        check(inbound_write_32_tdata_o, 32'hA5C3_0F96);
        check({31'h0, core_in_wide_ready_o}, 32'h0);
        stall = 1'b0;
        repeat (6) @(negedge core_clk_i);
        check(got_data, 32'hA5C3_0F96);
        check({24'h0, got_count}, 32'h1);
        stall = 1'b1;
        push(1'b0, 32'h0000_003C);
        wait_hi(1);
        check({24'h0, inbound_write_8_tdata_o}, 32'h3C);
        inbound_write_8_tready_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        check({31'h0, inbound_write_8_tvalid_o}, 32'h0);
        inbound_write_8_tready_i = 1'b0;
    endtask

    task automatic t_outbound();
        int n;
        send = 1'b1;
        @(negedge core_clk_i);
        send = 1'b0;
        wait_hi(2);
        repeat (3) @(negedge core_clk_i);
        check({31'h0, core_out_wide_o.valid}, 32'h1);
        check(core_out_wide_o.data, 32'h1234_5678);
        core_out_wide_ready_i = 1'b1;
        @(negedge core_clk_i);
        check({31'h0, core_out_wide_o.valid}, 32'h0);
        // byte word offered by the bench, held until ready is seen on an enable cycle
        outbound_read_8_tdata_i = 8'h5A;
        outbound_read_8_tvalid_i = 1'b1;
        for (n = 0; n < 40 && !(outbound_read_8_tready_o === 1'b1
            && application_clock_ce_o === 1'b1); n++)
            @(negedge core_clk_i);
        check({31'h0, outbound_read_8_tready_o & application_clock_ce_o}, 32'h1);
        @(negedge core_clk_i);
        outbound_read_8_tvalid_i = 1'b0;
        check({23'h0, core_out_byte_o.valid, core_out_byte_o.data}, 32'h15A);
    endtask

    task automatic t_loop();
        loopback_en_i = 1'b1;
        core_out_byte_ready_i = 1'b1;
        push(1'b1, 32'h0BAD_F00D);
        check({31'h0, outbound_read_32_tready_o}, 32'h0);
        wait_hi(2);
        check(core_out_wide_o.data, 32'h0BAD_F00D);
        push(1'b0, 32'h0000_0081);
        wait_hi(3);
        check({24'h0, core_out_byte_o.data}, 32'h81);
        check({31'h0, outbound_read_8_tready_o}, 32'h0);
        loopback_en_i = 1'b0;
    endtask

    // closing a file drops its held word and resets the attached logic
    task automatic t_close();
        push(1'b1, 32'h7E81_42C3);
        wait_hi(0);
        file_open_i = 4'hC;
        @(negedge core_clk_i);
        check({28'h0, file_open_o}, 32'hC);
        @(negedge core_clk_i);
        check({31'h0, inbound_write_32_tvalid_o}, 32'h0);
        check({24'h0, got_count}, 32'h0);
        file_open_i = 4'hF;
        @(negedge core_clk_i);
        check({28'h0, file_open_o}, 32'hF);
        check({31'h0, core_in_wide_ready_o}, 32'h1);
    endtask

    task automatic t_seek();
        seek_read_req_i = 1'b1;
        @(negedge core_clk_i);
        seek_read_req_i = 1'b0;
        check({31'h0, seek_eof_o}, 32'h1);
        @(negedge core_clk_i);
        check({31'h0, seek_eof_o}, 32'h0);
        check({31'h0, seek_write_ready_o}, 32'h0);
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        t_open();
        t_inbound();
        t_outbound();
        t_loop();
        t_seek();
        t_close();
        close_out();
    end

    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #300000;
        fails++;
        close_out();
    end
endmodule
